// ===== logic/gpio_function_mux_alarm_out.sv
// multifunction pin logic: per-pin function select, alarm outputs, sticky status
// assumes all inputs synchronous to ref_clk in value, pins pass a two-stage sync
// assumes configuration inputs held steady by software between changes
// assumes alarm sources are levels owned by the monitor and loop blocks
// assumes the pad ring resolves pin_out, pin_oe and the pull enables
`timescale 1ns/1ps
`include "gpio_mux_map.svh"
module gpio_function_mux_alarm_out
(
    // clock, reset and reset sequence state
    input  wire logic                        ref_clk,
    input  wire logic                        rst,
    input  wire logic                        reset_done,

    // per-pin configuration
    input  wire logic [`NUM_PINS*4-1:0]      pin_mode,
    input  wire logic [`NUM_PINS-1:0]        pin_out_level,
    input  wire logic [`NUM_PINS-1:0]        pin_invert,
    input  wire logic [`NUM_PINS*2-1:0]      pin_source_sel,
    input  wire logic [`NUM_PINS-1:0]        pin_enable,
    input  wire logic [`NUM_PINS-1:0]        pin_open_drain,
    input  wire logic [`NUM_PINS-1:0]        pin_pull_down,
    input  wire logic [`NUM_PINS*8-1:0]      pin_out_mask,
    input  wire logic [`NUM_PINS*12-1:0]     pin_alert_mask,
    input  wire logic [1:0]                  pin_supply_level,
    input  wire logic                        alarm_enable,

    // alarm sources and software clears
    input  wire logic [`NUM_REFS-1:0]        signal_loss_live,
    input  wire logic [`NUM_LOOPS-1:0]       loop_locked,
    input  wire logic [`NUM_LOOPS-1:0]       loop_holdover,
    input  wire logic [`NUM_ALARMS-1:0]      sticky_clear,
    input  wire logic                        ref_stage_full,

    // pad side
    input  wire logic [`NUM_PINS-1:0]        pin_in,
    output logic      [`NUM_PINS-1:0]        pin_out,
    output logic      [`NUM_PINS-1:0]        pin_oe,
    output logic      [`NUM_PINS-1:0]        pin_pull_up_en,
    output logic      [`NUM_PINS-1:0]        pin_pull_down_en,
    output logic      [1:0]                  pin_supply_sel,

    // status and controls toward the timing core
    output logic      [`NUM_PINS-1:0]        pin_level_status,
    output logic      [`NUM_ALARMS-1:0]      alarm_live,
    output logic      [`NUM_ALARMS-1:0]      alarm_sticky,
    output logic      [`NUM_OUTS-1:0]        out_clock_disable,
    output logic                             ref_clock_in,
    output logic                             ref_clock_valid,
    output logic                             manual_sel_high,
    output logic                             manual_sel_valid,
    output logic                             osc_step_up,
    output logic                             osc_step_down,
    output logic                             ref_disqualify
);
    ////////////////////////////////////////////////////////////////////////////
    // state record
    typedef struct packed
    {
        // synchroniser and edge history
        logic [`NUM_PINS-1:0]   sync1;
        logic [`NUM_PINS-1:0]   sync2;
        logic [`NUM_PINS-1:0]   prev;

        // alarm history and sticky status
        logic [`NUM_ALARMS-1:0] live_prev;
        logic [`NUM_ALARMS-1:0] sticky;

        // registered pad drive and level status
        logic [`NUM_PINS-1:0]   level;
        logic [`NUM_PINS-1:0]   out;
        logic [`NUM_PINS-1:0]   oe;

        // registered controls toward the timing core
        logic [`NUM_OUTS-1:0]   dis;
        logic                   ref_in;
        logic                   ref_ok;
        logic                   sel_hi;
        logic                   sel_ok;
        logic                   up;
        logic                   down;
        logic                   disq;
    } state_t;

    state_t state;
    state_t next_state;

    // combinational helpers shared by the pin processes
    logic [`NUM_ALARMS-1:0]    live_now;
    logic [`NUM_PINS-1:0]      rise;
    wire logic [`NUM_PINS-1:0] drive;
    wire logic [`NUM_PINS-1:0] drives_out;

    // mode of one pin from the packed mode field
    function automatic gpio_mux_pkg::pin_mode_t mode_of(input logic [`NUM_PINS*4-1:0] m,
                                                          input int idx);
        mode_of = gpio_mux_pkg::pin_mode_t'(m[idx*4 +: 4]);
    endfunction : mode_of

    // position of a selected alarm in the live and sticky vectors
    function automatic logic [3:0] alarm_index(input int base,
                                               input logic [1:0] sel);
        alarm_index = 4'(base) + {2'h0, sel};
    endfunction : alarm_index

    // alarm layout: refs 0..3 signal loss, 4..7 loop unlock, 8..11 holdover
    assign live_now = {loop_holdover, ~loop_locked, signal_loss_live} &
                      {`NUM_ALARMS{alarm_enable}};

    // edges are taken after the synchroniser; prev resets low, so a pin
    // idling high through reset shows one edge, which reset_done masks
    // while the reset sequence still runs
    assign rise = state.sync2 & ~state.prev;

    ////////////////////////////////////////////////////////////////////////////
    // per-pin output value and drive decision
    genvar g;
    generate
        for (g = 0; g < `NUM_PINS; g = g + 1)
        begin : g_pin
            logic [1:0] src;
            logic       value;
            logic       active;
            assign src = pin_source_sel[g*2 +: 2];
            // one process per pin owns its own value and drive flag
            always_comb
            begin
                value = 1'h0;
                active = 1'h1;
                case (mode_of(pin_mode, g))
                    gpio_mux_pkg::MODE_OUTPUT:
                        value = pin_out_level[g];
                    gpio_mux_pkg::MODE_LOSS_SIGNAL:
                        value = live_now[alarm_index(`ALARM_LOSS_BASE, src)]
                                ^ pin_invert[g];
                    gpio_mux_pkg::MODE_LOCK_LIVE:
                        value = live_now[alarm_index(`ALARM_LOCK_BASE, src)];
                    gpio_mux_pkg::MODE_LOCK_STICKY:
                        value = state.sticky[alarm_index(`ALARM_LOCK_BASE, src)]
                                ^ pin_invert[g];
                    gpio_mux_pkg::MODE_HOLD_LIVE:
                        value = live_now[alarm_index(`ALARM_HOLD_BASE, src)];
                    gpio_mux_pkg::MODE_HOLD_STICKY:
                        value = state.sticky[alarm_index(`ALARM_HOLD_BASE, src)]
                                ^ pin_invert[g];
                    gpio_mux_pkg::MODE_ALERT:
                        value = (|(state.sticky & pin_alert_mask[g*12 +: 12]))
                                ^ pin_invert[g];
                    default:
                        active = 1'h0;
                endcase
            end

            // per-pin results gathered into the shared vectors
            assign drive[g]      = value;
            assign drives_out[g] = active;
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // next-state logic
    always_comb
    begin
        next_state = state;

        // two flip-flop synchroniser, then history for edge detection
        next_state.sync1 = pin_in;
        next_state.sync2 = state.sync1;
        next_state.prev = state.sync2;
        next_state.level = state.sync2;
        next_state.live_prev = live_now;

        // set wins over clear: a change racing the software clear keeps
        // the bit set, so no alarm edge is lost while it is serviced
        next_state.sticky = (state.sticky & ~sticky_clear)
                            | (live_now ^ state.live_prev);

        // controls stay idle unless a pin in the matching mode asks
        next_state.dis = '0;
        next_state.ref_in = 1'b0;
        next_state.ref_ok = 1'b0;
        next_state.sel_hi = 1'b0;
        next_state.sel_ok = 1'b0;
        next_state.up = 1'b0;
        next_state.down = 1'b0;
        next_state.disq = 1'b0;
        next_state.out = '0;
        next_state.oe = '0;
        for (int i = 0; i < `NUM_PINS; i++)
        begin
            if (reset_done && pin_enable[i])
            begin
                // open drain drives only the low level; the high level is
                // left to the pull-up so a shared line never fights
                next_state.out[i] = drive[i];
                next_state.oe[i] = drives_out[i] &&
                                   (!pin_open_drain[i] || !drive[i]);
                case (mode_of(pin_mode, i))
                    gpio_mux_pkg::MODE_OUT_DISABLE:
                        if (state.sync2[i])
                        begin
                            next_state.dis = next_state.dis
                                             | pin_out_mask[i*8 +: 8];
                        end
                    gpio_mux_pkg::MODE_REF_CLOCK:
                        if (!ref_stage_full)
                        begin
                            next_state.ref_in = state.sync2[i];
                            next_state.ref_ok = 1'b1;
                        end
                    gpio_mux_pkg::MODE_MANUAL_SEL:
                    begin
                        next_state.sel_hi = state.sync2[i];
                        next_state.sel_ok = 1'b1;
                    end
                    gpio_mux_pkg::MODE_INCREMENT:
                        if (rise[i])
                        begin
                            next_state.up = 1'b1;
                        end
                    gpio_mux_pkg::MODE_DECREMENT:
                        if (rise[i])
                        begin
                            next_state.down = 1'b1;
                        end
                    gpio_mux_pkg::MODE_DISQUALIFY:
                        if (state.sync2[i])
                        begin
                            next_state.disq = 1'b1;
                        end
                    default:
                        next_state.disq = next_state.disq;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register
    // asynchronous reset clears every flop; pins stay undriven until reset_done
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            state <= '0;
        end
        else
        begin
            state <= next_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pad side outputs
    assign pin_out           = state.out;
    assign pin_oe            = state.oe;
    assign pin_pull_down_en  = pin_pull_down;
    assign pin_pull_up_en    = ~pin_pull_down;
    assign pin_supply_sel    = pin_supply_level;

    // status seen by software
    assign pin_level_status  = state.level;
    assign alarm_live        = live_now;
    assign alarm_sticky      = state.sticky;

    // controls toward the timing core
    assign out_clock_disable = state.dis;
    assign ref_clock_in      = state.ref_in;
    assign ref_clock_valid   = state.ref_ok;
    assign manual_sel_high   = state.sel_hi;
    assign manual_sel_valid  = state.sel_ok;
    assign osc_step_up       = state.up;
    assign osc_step_down     = state.down;
    assign ref_disqualify    = state.disq;
endmodule : gpio_function_mux_alarm_out

// ===== logic/gpio_mux_map.svh
// constants for the multifunction pin block: mode width, counts, alarm bases, reset values
// assumes inclusion by the package and the pin block only
`ifndef GPIO_MUX_MAP_SVH
`define GPIO_MUX_MAP_SVH
`define NUM_PINS         16
`define NUM_REFS         4
`define NUM_LOOPS        4
`define NUM_OUTS         8
`define NUM_ALARMS       12
`define MODE_W           4
`define STEP_W           16
`define ALARM_LOSS_BASE  0
`define ALARM_LOCK_BASE  4
`define ALARM_HOLD_BASE  8
`define PULL_UP_RESET    1'b1
`define OD_RESET         1'b0
`define PIN_EN_RESET     1'b1
`endif

// ===== logic/gpio_mux_pkg.sv
// types for the multifunction pin block
// assumes gpio_mux_map.svh on the include path
`include "gpio_mux_map.svh"
package gpio_mux_pkg;
    typedef enum logic [3:0]
    {
        MODE_INPUT       = 4'h0,
        MODE_OUTPUT      = 4'h1,
        MODE_LOSS_SIGNAL = 4'h2,
        MODE_LOCK_LIVE   = 4'h3,
        MODE_LOCK_STICKY = 4'h4,
        MODE_HOLD_LIVE   = 4'h5,
        MODE_HOLD_STICKY = 4'h6,
        MODE_ALERT       = 4'h7,
        MODE_OUT_DISABLE = 4'h8,
        MODE_REF_CLOCK   = 4'h9,
        MODE_MANUAL_SEL  = 4'hA,
        MODE_INCREMENT   = 4'hB,
        MODE_DECREMENT   = 4'hC,
        MODE_DISQUALIFY  = 4'hD
    } pin_mode_t;
endpackage : gpio_mux_pkg

// ===== testbench/gpio_mux_checker_properties.sv
// assertions for the multifunction pin block, bound to its top module
// assumes one clock domain and live alarms laid out as holdover, unlock, loss
`timescale 1ns/1ps
module gpio_mux_checker
(
    input wire logic        ref_clk,
    input wire logic        rst,
    input wire logic        reset_done,
    input wire logic        alarm_enable,
    input wire logic [1:0]  pin_supply_level,
    input wire logic [1:0]  pin_supply_sel,
    input wire logic [3:0]  signal_loss_live,
    input wire logic [3:0]  loop_locked,
    input wire logic [3:0]  loop_holdover,
    input wire logic [11:0] sticky_clear,
    input wire logic [11:0] alarm_live,
    input wire logic [11:0] alarm_sticky,
    input wire logic [15:0] pin_enable,
    input wire logic [15:0] pin_open_drain,
    input wire logic [15:0] pin_pull_down,
    input wire logic [15:0] pin_pull_up_en,
    input wire logic [15:0] pin_out,
    input wire logic [15:0] pin_oe
);
    logic [11:0] live_q;
    wire  [11:0] chg = alarm_live ^ live_q;
    wire  [11:0] clr = sticky_clear & ~chg;
    wire  [15:0] may = pin_enable & {16{reset_done}};
    // last live alarms, cleared by reset like the block's own copy
    always_ff @(posedge ref_clk or posedge rst)
        if (rst)
            live_q <= 12'h000;
        else
            live_q <= alarm_live;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    a_live_map:
        assert property (alarm_live == ({loop_holdover, ~loop_locked, signal_loss_live}
                                        & {12{alarm_enable}}))
        else $error("live alarms differ from their sources");
    a_sticky_set:
        assert property (chg != 12'h000 |=> (alarm_sticky & $past(chg)) == $past(chg))
        else $error("alarm change left its sticky bit clear");
    a_sticky_hold:
        assert property (1'b1 |=> ($past(alarm_sticky) & ~$past(sticky_clear)
                                   & ~alarm_sticky) == 12'h000)
        else $error("sticky bit fell without a clear");
    a_sticky_clear:
        assert property (clr != 12'h000 |=> (alarm_sticky & $past(clr)) == 12'h000)
        else $error("sticky bit survived its clear");
    a_drive_gated:
        assert property (1'b1 |=> (pin_oe & ~$past(may)) == 16'h0000)
        else $error("pin driven while disabled or in reset");
    a_drain_low:
        assert property (1'b1 |=> (pin_oe & $past(pin_open_drain) & pin_out) == 16'h0000)
        else $error("open drain pin driven high");
    a_pull_choice:
        assert property (pin_pull_up_en == ~pin_pull_down)
        else $error("pull selection wrong");
    a_supply_pass:
        assert property (pin_supply_sel == pin_supply_level)
        else $error("supply level not passed on");
endmodule : gpio_mux_checker
bind gpio_function_mux_alarm_out gpio_mux_checker chk_u (.*);

// ===== testbench/gpio_board_model.sv
// board model: resolves each pin wire from block drive, board drive and pull
// assumes the bench supplies the board's drive value and enable per pin
`timescale 1ns/1ps
module gpio_board_model
(
    input wire logic [15:0] pin_out,
    input wire logic [15:0] pin_oe,
    input wire logic [15:0] pin_pull_up_en,
    input wire logic [15:0] ext_en,
    input wire logic [15:0] ext_val,
    output logic     [15:0] pin_wire
);
    // block drive first, then board drive, else the internal pull
    assign pin_wire = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
                    | (~pin_oe & ~ext_en & pin_pull_up_en);
endmodule : gpio_board_model

// ===== testbench/gpio_function_mux_alarm_out_tb.sv
// self-checking bench for the multifunction pin block, one task per scenario
// assumes package, checker and board model compiled before it
`timescale 1ns/1ps
module gpio_function_mux_alarm_out_tb;
    logic         ref_clk = 1'b0, rst = 1'b1, reset_done = 1'b0, alarm_enable = 1'b1;
    logic         ref_stage_full = 1'b1;
    logic [1:0]   pin_supply_level = 2'h2;
    logic [3:0]   signal_loss_live = 4'h0, loop_locked = 4'hF, loop_holdover = 4'h0;
    logic [11:0]  sticky_clear = 12'h000;
    logic [15:0]  pin_out_level = 16'h0001, pin_invert = 16'h0108, pin_enable = 16'hFFFF;
    logic [15:0]  pin_open_drain = 16'h0000, pin_pull_down = 16'h0000;
    logic [15:0]  ext_en = 16'hFFFF, ext_val = 16'hA5C3;
    logic [31:0]  pin_source_sel = 32'h0003_1250;
    logic [63:0]  pin_mode = 64'h0;
    logic [127:0] pin_out_mask = {32'h0, 8'h06, 8'h81, 80'h0};
    logic [191:0] pin_alert_mask = {72'h0, 12'h010, 108'h0};
    logic [15:0]  pin_in, pin_out, pin_oe, pull_up, pull_dn, level;
    logic [11:0]  live, sticky;
    logic [7:0]   clk_off;
    logic [1:0]   supply;
    logic         sel_hi, sel_ok, step_up, step_dn, disq, ref_ok, ref_in;
    int           fails = 0, tests_run = 0;
    gpio_function_mux_alarm_out dut_u
    (
        .ref_clk(ref_clk), .rst(rst), .reset_done(reset_done), .pin_mode(pin_mode),
        .pin_out_level(pin_out_level), .pin_invert(pin_invert), .pin_source_sel(pin_source_sel),
        .pin_enable(pin_enable), .pin_open_drain(pin_open_drain), .pin_pull_down(pin_pull_down),
        .pin_out_mask(pin_out_mask), .pin_alert_mask(pin_alert_mask), .pin_in(pin_in),
        .pin_supply_level(pin_supply_level), .alarm_enable(alarm_enable),
        .signal_loss_live(signal_loss_live), .loop_locked(loop_locked),
        .loop_holdover(loop_holdover), .sticky_clear(sticky_clear),
        .ref_stage_full(ref_stage_full), .pin_out(pin_out), .pin_oe(pin_oe),
        .pin_pull_up_en(pull_up), .pin_pull_down_en(pull_dn),
        .pin_supply_sel(supply), .pin_level_status(level), .alarm_live(live),
        .alarm_sticky(sticky), .out_clock_disable(clk_off), .ref_clock_in(ref_in),
        .ref_clock_valid(ref_ok), .manual_sel_high(sel_hi), .manual_sel_valid(sel_ok),
        .osc_step_up(step_up), .osc_step_down(step_dn), .ref_disqualify(disq)
    );
    gpio_board_model brd_u (.pin_out(pin_out), .pin_oe(pin_oe), .pin_pull_up_en(pull_up),
        .ext_en(ext_en), .ext_val(ext_val), .pin_wire(pin_in));
    initial forever #4 ref_clk = ~ref_clk;
    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            fails++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : tick
    // software clear pulse, one cycle wide
    task clr(input logic [11:0] c);
        @(posedge ref_clk);
        sticky_clear <= c;
        @(posedge ref_clk);
        sticky_clear <= 12'h000;
    endtask : clr
    task t_pins;
        @(posedge ref_clk);
        pin_mode <= 64'h11;
        ext_en <= 16'hFFFC;
        tick(4);
        chk({pin_oe, pull_up}, {16'h0000, 16'hFFFF});
        chk({pull_dn, 14'h0, supply}, {16'h0000, 16'h0002});
        @(posedge ref_clk);
        reset_done <= 1'b1;
        tick(4);
        chk({pin_oe, level}, {16'h0003, 16'hA5C1});
        @(posedge ref_clk);
        pin_open_drain <= 16'h0003;
        pin_out_level <= 16'h0002;
        tick(3);
        chk({pin_in[1:0], pin_oe[1:0]}, 4'h9);
        @(posedge ref_clk);
        pin_enable <= 16'hFFFE;
        pin_pull_down <= 16'h0002;
        tick(3);
        chk({pin_in[1:0], pin_oe[1:0], pull_up}, {4'h4, 16'hFFFD});
        chk(pull_dn, 16'h0002);
    endtask : t_pins
    task t_live;
        @(posedge ref_clk);
        pin_mode <= 64'h0253_2211;
        ext_en <= 16'hFF80;
        pin_enable <= 16'hFFFF;
        pin_pull_down <= 16'h0000;
        pin_open_drain <= 16'h0000;
        signal_loss_live <= 4'h2;
        loop_locked <= 4'hB;
        loop_holdover <= 4'h1;
        tick(3);
        chk({live, pin_in[6:2]}, {12'h142, 5'b11101});
        @(posedge ref_clk);
        alarm_enable <= 1'b0;
        tick(3);
        chk({live, pin_in[6:2]}, {12'h000, 5'b00010});
        @(posedge ref_clk);
        alarm_enable <= 1'b1;
    endtask : t_live
    task t_sticky;
        @(posedge ref_clk);
        pin_mode <= 64'h76_4253_2211;
        ext_en <= 16'hFC00;
        clr(12'hFFF);
        tick(2);
        chk({sticky, pin_in[9:7]}, {12'h000, 3'b010});
        @(posedge ref_clk);
        loop_locked <= 4'hA;
        signal_loss_live <= 4'h3;
        tick(3);
        chk({sticky, pin_in[9:7]}, {12'h011, 3'b111});
        @(posedge ref_clk);
        loop_locked <= 4'hB;
        sticky_clear <= 12'h010;
        @(posedge ref_clk);
        sticky_clear <= 12'h000;
        tick(2);
        chk(sticky, 12'h011);
        clr(12'h010);
        tick(3);
        chk({sticky, pin_in[9:7]}, {12'h001, 3'b010});
        @(posedge ref_clk);
        loop_holdover <= 4'h9;
        tick(3);
        chk({sticky, pin_in[9:7]}, {12'h801, 3'b000});
    endtask : t_sticky
    task t_inputs;
        @(posedge ref_clk);
        pin_mode <= 64'hDCBA_8876_4253_2291;
        ext_en <= 16'hFC02;
        ext_val <= 16'h0002;
        tick(4);
        chk({clk_off, ref_ok, ref_in}, 10'h000);
        @(posedge ref_clk);
        ext_val <= 16'h9402;
        ref_stage_full <= 1'b0;
        tick(2);
        chk(clk_off, 8'h00);
        tick(1);
        chk({clk_off, sel_hi, sel_ok, disq, ref_ok, ref_in}, {8'h81, 5'h1F});
        @(posedge ref_clk);
        ext_val <= 16'h0C02;
        tick(3);
        chk({clk_off, sel_hi, disq}, {8'h87, 2'b00});
        @(posedge ref_clk);
        ext_val <= 16'h2C02;
        tick(3);
        chk({step_up, step_dn}, 2'b10);
        @(posedge ref_clk);
        ext_val <= 16'h4C02;
        tick(3);
        chk({step_up, step_dn}, 2'b01);
        tick(1);
        chk({step_up, step_dn}, 2'b00);
    endtask : t_inputs
    task report_and_stop;
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : report_and_stop
    // main sequence after a 16 cycle reset
    initial
    begin
        repeat (16) @(posedge ref_clk);
        rst <= 1'b0;
        t_pins;
        t_live;
        t_sticky;
        t_inputs;
        report_and_stop;
    end
    // hang guard, far beyond the fewer than one hundred cycles needed
    initial
    begin
        #100000;
        fails++;
        report_and_stop;
    end
endmodule : gpio_function_mux_alarm_out_tb
